// File: inc/reg_access_pkg.sv
`default_nettype none
package reg_access_pkg;
  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_SR1_RD    = 8'h05;
  localparam logic [7:0] OP_SR2_RD    = 8'h07;
  localparam logic [7:0] OP_CR1_RD    = 8'h35;
  localparam logic [7:0] OP_CR2_RD    = 8'h3F;
  localparam logic [7:0] OP_CR4_RD    = 8'h45;
  localparam logic [7:0] OP_CR5_RD    = 8'h5E;
  localparam logic [7:0] OP_GEN_WR    = 8'h71;
  localparam logic [7:0] OP_GEN_RD    = 8'h65;

  // ****************************************************************
  // Field layout, lengths and defaults
  // ****************************************************************
  localparam int unsigned CNT_W        = 5;
  localparam logic [4:0]  OPC_BITS     = 5'h08;
  localparam logic [4:0]  ADDR_BITS    = 5'h18;
  localparam logic [4:0]  DATA_BITS    = 5'h08;
  localparam int unsigned WIP_BIT      = 0;
  localparam int unsigned WEL_BIT      = 1;
  localparam int unsigned SWD_BIT      = 7;
  localparam int unsigned NV_LO_BIT    = 2;
  localparam int unsigned RLC_LO_BIT   = 0;
  localparam int unsigned RLC_HI_BIT   = 1;
  localparam logic [2:0]  LAT_BASE     = 3'h1;
  localparam logic [5:0]  SR1_NV_DFLT  = 6'h00;
  localparam logic [7:0]  CR_NV_DFLT   = 8'h00;
  localparam logic [7:0]  PAGE_VOL     = 8'h07;
  localparam logic [7:0]  PAGE_BOTH    = 8'h00;
  localparam logic [7:0]  LO_SR1       = 8'h00;
  localparam logic [7:0]  LO_SR2       = 8'h01;
  localparam logic [7:0]  LO_CR1       = 8'h02;
  localparam logic [7:0]  LO_CR2       = 8'h03;
  localparam logic [7:0]  LO_CR4       = 8'h05;
  localparam logic [7:0]  LO_CR5       = 8'h06;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    RI_SR1 = 3'h0, RI_SR2 = 3'h1, RI_CR1 = 3'h2, RI_CR2 = 3'h3,
    RI_CR4 = 3'h4, RI_CR5 = 3'h5, RI_NONE = 3'h7
  } reg_idx_t;
  typedef enum logic [1:0] {
    PROTO_SINGLE = 2'h0, PROTO_DUAL = 2'h1, PROTO_QUAD = 2'h2
  } proto_t;
  typedef enum logic [2:0] {
    PH_OPC = 3'h0, PH_ADDR = 3'h1, PH_DUMMY = 3'h3, PH_OUT = 3'h2,
    PH_DIN = 3'h6, PH_IGN = 3'h7
  } phase_t;
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       wp_n;
    logic [3:0] io;
  } pins_t;
endpackage
`default_nettype wire

// File: rtl/write_latch_and_register_access.sv
// Overview of operation
// - Opcode 06h sets the write enable latch
// - Write commands need the latch set
// - Set latch on select rise, full opcode
// - Opcode 04h clears the write enable latch
// - Clear ignored while write in progress
// - Clear latch on select rise, full opcode
// - Reset reloads volatile bits from non-volatile
// - Opcode 01 is status write, no address
// - Opcodes 05, 07 read status registers
// - Opcodes 35, 3F, 45, 5E read configs
// - Opcodes 71, 65 generic, three-byte address
// - Reads insert latency-code dummy cycles
// - Status write programs non-volatile copy
// - Status write blocked by disable bit, pin low
// - Status write needs latch, else discarded
// - Latch auto-clears when status write ends
// - Status one read returns volatile byte
// - Status one shows protection, latch, busy
// - Generic write takes one data byte
// - Generic write blocked by disable bit, pin low
`timescale 1ns/1ps
`default_nettype none
module write_latch_and_register_access
  import reg_access_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_dev_reset,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_wp_n,
  input  wire logic [3:0] i_io,
  input  wire proto_t     i_proto,
  input  wire logic       i_write_in_progress,
  input  wire logic [7:0] i_status_reg_two,
  output logic      [3:0] o_io_out,
  output logic      [3:0] o_io_oe,
  output logic            o_write_enable_latch,
  output logic      [7:0] o_status_reg_one,
  output logic            o_write_permit
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [CNT_W-1:0] lane_w(proto_t p);
    case (p)
      PROTO_DUAL: lane_w = 5'h02;
      PROTO_QUAD: lane_w = 5'h04;
      default:    lane_w = 5'h01;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(logic [7:0] sr, logic [3:0] io, proto_t p);
    case (p)
      PROTO_DUAL: shift_in = {sr[5:0], io[1:0]};
      PROTO_QUAD: shift_in = {sr[3:0], io[3:0]};
      default:    shift_in = {sr[6:0], io[0]};
    endcase
  endfunction

  function automatic reg_idx_t lo_index(logic [7:0] lo);
    case (lo)
      LO_SR1:  lo_index = RI_SR1;
      LO_SR2:  lo_index = RI_SR2;
      LO_CR1:  lo_index = RI_CR1;
      LO_CR2:  lo_index = RI_CR2;
      LO_CR4:  lo_index = RI_CR4;
      LO_CR5:  lo_index = RI_CR5;
      default: lo_index = RI_NONE;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  pins_t pins_raw;
  pins_t s1_ff;
  pins_t s2_ff;
  pins_t s3_ff;
  assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, wp_n: i_wp_n, io: i_io};

  // Two stages before use; third stage only feeds edge detectors
  always_ff @(posedge i_ref_clk) begin
    s1_ff <= pins_raw;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  wire sclk_rise = s2_ff.sclk & ~s3_ff.sclk;
  wire sclk_fall = ~s2_ff.sclk & s3_ff.sclk;
  wire cs_rise   = s2_ff.cs_n & ~s3_ff.cs_n;
  wire active    = ~s2_ff.cs_n;

  // ****************************************************************
  // Register state
  // ****************************************************************
  phase_t           phase_ff;
  phase_t           nxt_phase;
  logic [CNT_W-1:0] cnt_ff;
  logic [2:0]       dum_cnt_ff;
  logic [2:0]       out_cnt_ff;
  logic [7:0]       in_sr_ff;
  logic [7:0]       out_sr_ff;
  logic [7:0]       opcode_ff;
  logic [23:0]      addr_ff;
  logic [7:0]       data_ff;
  logic             opc_done_ff;
  logic             data_done_ff;
  logic             latch_ff;
  logic [5:0]       sr1_v_ff;
  logic [5:0]       sr1_nv_ff;
  logic [7:0]       cr_v_ff [4];
  logic [7:0]       cr_nv_ff [4];

  // ****************************************************************
  // Shift-in and phase decode
  // ****************************************************************
  wire [CNT_W-1:0] w        = lane_w(i_proto);
  wire [7:0]       in_nxt   = shift_in(in_sr_ff, s2_ff.io, i_proto);
  wire [CNT_W-1:0] cnt_nxt  = cnt_ff + w;
  wire [CNT_W-1:0] need     = (phase_ff == PH_ADDR) ? ADDR_BITS :
                              (phase_ff == PH_DIN) ? DATA_BITS : OPC_BITS;
  wire             full     = sclk_rise & (cnt_nxt == need);
  wire             rd_direct = (in_nxt == OP_SR1_RD) | (in_nxt == OP_SR2_RD) |
                              (in_nxt == OP_CR1_RD) | (in_nxt == OP_CR2_RD) |
                              (in_nxt == OP_CR4_RD) | (in_nxt == OP_CR5_RD);
  wire [1:0]       rlc      = {cr_v_ff[3][RLC_HI_BIT], cr_v_ff[3][RLC_LO_BIT]};
  wire [2:0]       dum_need = LAT_BASE + {1'b0, rlc};
  wire             dum_end  = sclk_rise & (dum_cnt_ff == dum_need - 3'h1);

  // Phase sequencing; select high always returns to the opcode phase
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_OPC: begin
        if (full) begin
          if (in_nxt == OP_STAT_WR) nxt_phase = PH_DIN;
          else if (in_nxt == OP_GEN_WR || in_nxt == OP_GEN_RD) nxt_phase = PH_ADDR;
          else if (rd_direct) nxt_phase = PH_DUMMY;
          else nxt_phase = PH_IGN;
        end
      end
      PH_ADDR:  if (full) nxt_phase = (opcode_ff == OP_GEN_WR) ? PH_DIN : PH_DUMMY;
      PH_DIN:   if (full) nxt_phase = PH_IGN;
      PH_DUMMY: if (dum_end) nxt_phase = PH_OUT;
      PH_OUT:   nxt_phase = PH_OUT;
      PH_IGN:   nxt_phase = PH_IGN;
      default:  nxt_phase = PH_IGN;
    endcase
    if (!active) nxt_phase = PH_OPC;
  end

  // Frame tracking; bit counter restarts at every phase change, dummy counter only at deselect
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !active) begin
      phase_ff   <= PH_OPC;
      cnt_ff     <= '0;
      dum_cnt_ff <= '0;
      in_sr_ff   <= '0;
    end else begin
      phase_ff   <= nxt_phase;
      if (sclk_rise) in_sr_ff <= in_nxt;
      cnt_ff     <= (nxt_phase != phase_ff) ? '0 : (sclk_rise ? cnt_nxt : cnt_ff);
      dum_cnt_ff <= (phase_ff == PH_DUMMY && sclk_rise) ? dum_cnt_ff + 3'h1 : dum_cnt_ff;
    end
  end

  // Command fields; done flags only count whole bytes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !active) begin
      opc_done_ff  <= 1'b0;
      data_done_ff <= 1'b0;
      if (i_rst) begin
        opcode_ff <= '0;
        addr_ff   <= '0;
        data_ff   <= '0;
      end
    end else begin
      if (phase_ff == PH_OPC && full) begin
        opcode_ff   <= in_nxt;
        opc_done_ff <= 1'b1;
      end
      if (phase_ff == PH_ADDR && sclk_rise && cnt_nxt[2:0] == 3'h0)
        addr_ff <= {addr_ff[15:0], in_nxt};
      if (phase_ff == PH_DIN && full) begin
        data_ff      <= in_nxt;
        data_done_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command execution at the select rising edge
  // ****************************************************************
  wire       write_in_progress       = i_write_in_progress;
  wire       protect   = sr1_v_ff[SWD_BIT-NV_LO_BIT] & ~s2_ff.wp_n;
  wire       set_exec  = cs_rise & opc_done_ff & (opcode_ff == OP_SET_LATCH);
  wire       clr_exec  = cs_rise & opc_done_ff & (opcode_ff == OP_CLR_LATCH) & ~write_in_progress;
  wire       swr_exec  = cs_rise & data_done_ff & (opcode_ff == OP_STAT_WR) &
                         latch_ff & ~protect;
  reg_idx_t  widx;
  assign     widx      = lo_index(addr_ff[7:0]);
  wire       page_vol  = addr_ff[23:16] == PAGE_VOL;
  wire       page_both = addr_ff[23:16] == PAGE_BOTH;
  wire       addr_ok   = (page_vol | page_both) & (widx != RI_SR2) & (widx != RI_NONE);
  wire       gwr_exec  = cs_rise & data_done_ff & (opcode_ff == OP_GEN_WR) &
                         latch_ff & ~protect & addr_ok;
  wire       sr1_vol   = swr_exec | (gwr_exec & widx == RI_SR1);
  wire       sr1_nv    = swr_exec | (gwr_exec & widx == RI_SR1 & page_both);
  wire       cr_hit    = gwr_exec & (widx != RI_SR1);
  wire [1:0] cr_i      = 2'(widx - RI_CR1);

  // Latch: volatile, cleared by reset; one event source per frame
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_dev_reset) latch_ff <= 1'b0;
    else if (set_exec) latch_ff <= 1'b1;
    else if (clr_exec || swr_exec || gwr_exec) latch_ff <= 1'b0;
  end

  // Non-volatile copies hold factory values only after power-on
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sr1_nv_ff <= SR1_NV_DFLT;
      for (int k = 0; k < 4; k++) cr_nv_ff[k] <= CR_NV_DFLT;
    end else begin
      if (sr1_nv) sr1_nv_ff <= data_ff[7:NV_LO_BIT];
      if (cr_hit && page_both) cr_nv_ff[cr_i] <= data_ff;
    end
  end

  // Volatile copies take factory values on power-on reset, reload from non-volatile on device reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sr1_v_ff <= SR1_NV_DFLT;
      for (int k = 0; k < 4; k++) cr_v_ff[k] <= CR_NV_DFLT;
    end else if (i_dev_reset) begin
      sr1_v_ff <= sr1_nv_ff;
      for (int k = 0; k < 4; k++) cr_v_ff[k] <= cr_nv_ff[k];
    end else begin
      if (sr1_vol) sr1_v_ff <= data_ff[7:NV_LO_BIT];
      if (cr_hit) cr_v_ff[cr_i] <= data_ff;
    end
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  wire [7:0] sr1_byte = {sr1_v_ff, latch_ff, write_in_progress};
  reg_idx_t  ridx;
  assign ridx = (opcode_ff == OP_GEN_RD) ?
                ((addr_ff[23:16] == PAGE_VOL || addr_ff[23:16] == PAGE_BOTH) ?
                 lo_index(addr_ff[7:0]) : RI_NONE) :
                (opcode_ff == OP_SR1_RD) ? RI_SR1 : (opcode_ff == OP_SR2_RD) ? RI_SR2 :
                (opcode_ff == OP_CR1_RD) ? RI_CR1 : (opcode_ff == OP_CR2_RD) ? RI_CR2 :
                (opcode_ff == OP_CR4_RD) ? RI_CR4 : RI_CR5;
  wire [1:0] rcr_i   = 2'(ridx - RI_CR1);
  wire [7:0] rd_byte = (ridx == RI_SR1) ? sr1_byte :
                       (ridx == RI_SR2) ? i_status_reg_two :
                       (ridx == RI_NONE) ? 8'h00 : cr_v_ff[rcr_i];
  // A fresh byte is fetched at each boundary so the host sees live status
  wire [7:0] out_src = (out_cnt_ff == 3'h0) ? rd_byte : out_sr_ff;
  wire [3:0] lanes   = (i_proto == PROTO_QUAD) ? out_src[7:4] :
                       (i_proto == PROTO_DUAL) ? {2'h0, out_src[7:6]} :
                       {2'h0, out_src[7], 1'b0};
  wire [3:0] oe_mask = (i_proto == PROTO_QUAD) ? 4'hF :
                       (i_proto == PROTO_DUAL) ? 4'h3 : 4'h2;

  // Drive on falling sclk so data is stable for the host's rising sample
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !active) begin
      out_sr_ff  <= '0;
      out_cnt_ff <= '0;
      o_io_out   <= '0;
      o_io_oe    <= '0;
    end else if (phase_ff == PH_OUT && sclk_fall) begin
      o_io_out   <= lanes;
      o_io_oe    <= oe_mask;
      out_sr_ff  <= out_src << w;
      out_cnt_ff <= out_cnt_ff + w[2:0];
    end
  end

  // Status outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_write_enable_latch <= 1'b0;
      o_status_reg_one     <= '0;
      o_write_permit       <= 1'b0;
    end else begin
      o_write_enable_latch <= latch_ff;
      o_status_reg_one     <= sr1_byte;
      o_write_permit       <= latch_ff & ~write_in_progress;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  set_latch_a: assert property (set_exec && !i_dev_reset |=> latch_ff)
    else $error("latch not set after set command");
  clear_latch_a: assert property (clr_exec && !i_dev_reset |=> !latch_ff)
    else $error("latch not cleared after clear command");
  clear_busy_a: assert property (cs_rise && opc_done_ff && opcode_ff == OP_CLR_LATCH && write_in_progress
                                 && !i_dev_reset |=> latch_ff == $past(latch_ff))
    else $error("clear command acted while busy");
  nv_needs_latch_a: assert property ($changed(sr1_nv_ff) |-> $past(latch_ff))
    else $error("status copy changed without latch");
  nv_protect_a: assert property ($changed(sr1_nv_ff) |-> !$past(protect))
    else $error("status copy changed while protected");
  auto_clear_a: assert property (swr_exec ##1 !i_dev_reset |-> ##1 !o_write_enable_latch)
    else $error("latch survived status write");
  dummy_len_a: assert property (phase_ff == PH_DUMMY && active |=>
    (phase_ff == PH_OUT) == $past(sclk_rise && (dum_cnt_ff + 3'h1 == LAT_BASE + {1'b0, rlc})))
    else $error("wrong dummy count");
  oe_read_a: assert property (o_io_oe != 4'h0 |-> $past(phase_ff, 1) == PH_OUT)
    else $error("pins driven outside read data");
  permit_a: assert property (o_write_permit |-> $past(latch_ff) && !$past(write_in_progress))
    else $error("write permitted without latch");

  set_cov_c: cover property (set_exec);
  swr_cov_c: cover property (swr_exec);
  gwr_cov_c: cover property (gwr_exec && page_both);
  read_cov_c: cover property (phase_ff == PH_OUT && out_cnt_ff == 3'h0 && sclk_fall);
endmodule // write_latch_and_register_access
`default_nettype wire

// File: verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Serial bus master model, mode 0, clock parked low between frames
// ****************************************************************
module spi_host_model
  import reg_access_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire proto_t     i_proto,
  input  wire logic [3:0] i_io_out,
  input  wire logic [3:0] i_io_oe,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic      [3:0] o_io
);
  // Idle bus: deselected, clock low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io   = 4'h0;
  end

  // Half serial period is 10 reference cycles, so the full period is 80 ns
  task automatic half();
    repeat (10) @(posedge i_ref_clk);
    #1;
  endtask

  // One clock; released lanes toggle so a stale level never looks valid
  task automatic pulse(input bit released);
    half();
    o_sclk = 1'b1;
    half();
    o_sclk = 1'b0;
    if (released) o_io = ~o_io;
  endtask

  // Frame: nbits MSB first on the active lanes, dummy clocks, optional read byte
  task automatic frame(input logic [39:0] tx, input int nbits, input int dummy,
                       input bit rd, output logic [7:0] rx, output logic [3:0] oe);
    int w;
    w = (i_proto == PROTO_QUAD) ? 4 : ((i_proto == PROTO_DUAL) ? 2 : 1);
    rx = 8'h00;
    oe = 4'h0;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i += w) begin
      for (int b = 0; b < w; b++) o_io[w-1-b] = tx[39-i-b];
      pulse(1'b0);
    end
    for (int d = 0; d < dummy; d++) pulse(1'b1);
    for (int i = 0; rd && i < 8; i += w) begin
      half();
      for (int b = 0; b < w; b++) rx[7-i-b] = i_io_out[(w == 1) ? 1 : w-1-b];
      oe = i_io_oe;
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
      o_io = ~o_io;
    end
    half();
    o_cs_n = 1'b1;
    half();
  endtask
endmodule // spi_host_model
`default_nettype wire

// File: verif/write_latch_and_register_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Latch and register access bench
// ****************************************************************
module write_latch_and_register_access_tb
  import reg_access_pkg::*;
;
  logic       ref_clk, rst, dev_reset, wp_n, write_in_progress, sclk, cs_n, write_enable_latch, permit;
  logic [3:0] io, io_out, io_oe, oe;
  logic [7:0] sr2, sr1, rx;
  proto_t     proto;
  int         errors, n_tests, lat;

  // Reference clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  write_latch_and_register_access write_latch_and_register_access_i (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_dev_reset(dev_reset), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_wp_n(wp_n), .i_io(io), .i_proto(proto),
    .i_write_in_progress(write_in_progress), .i_status_reg_two(sr2), .o_io_out(io_out),
    .o_io_oe(io_oe), .o_write_enable_latch(write_enable_latch), .o_status_reg_one(sr1),
    .o_write_permit(permit));

  spi_host_model spi_host_model_i (
    .i_ref_clk(ref_clk), .i_proto(proto), .i_io_out(io_out), .i_io_oe(io_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  // Frame with no read phase
  task automatic cmd(input logic [39:0] tx, input int nbits);
    spi_host_model_i.frame(tx, nbits, 0, 1'b0, rx, oe);
  endtask

  // Generic write, always preceded by a latch set
  task automatic wr(input logic [23:0] addr, input logic [7:0] data);
    cmd({OP_SET_LATCH, 32'h0}, 8);
    cmd({OP_GEN_WR, addr, data}, 40);
  endtask

  // Register read at the current latency; byte and lane enables judged
  task automatic rd(input string what, input logic [39:0] tx, input int nbits,
                    input logic [7:0] exp);
    logic [7:0] eoe;
    eoe = (proto == PROTO_QUAD) ? 8'h0F : ((proto == PROTO_DUAL) ? 8'h03 : 8'h02);
    spi_host_model_i.frame(tx, nbits, lat, 1'b1, rx, oe);
    chk(what, exp, rx);
    chk("lane enables", eoe, {4'h0, oe});
  endtask

  // Inputs change just after a rising edge
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  // Set, clear while busy, clear, and a set cut short at seven bits
  task automatic t_latch();
    cmd({OP_SET_LATCH, 32'h0}, 8);
    chk("latch after set", 8'h01, {7'h0, write_enable_latch});
    chk("permit after set", 8'h01, {7'h0, permit});
    step();
    write_in_progress = 1'b1;
    cmd({OP_CLR_LATCH, 32'h0}, 8);
    chk("latch clear while busy", 8'h01, {7'h0, write_enable_latch});
    chk("permit while busy", 8'h00, {7'h0, permit});
    rd("status one busy", {OP_SR1_RD, 32'h0}, 8, 8'h03);
    step();
    write_in_progress = 1'b0;
    cmd({OP_CLR_LATCH, 32'h0}, 8);
    chk("latch after clear", 8'h00, {7'h0, write_enable_latch});
    cmd({7'h03, 33'h0}, 7);
    chk("latch after short set", 8'h00, {7'h0, write_enable_latch});
  endtask

  // Status write without latch, with latch, and under pin protection
  task automatic t_status();
    cmd({OP_STAT_WR, 8'hFC, 24'h0}, 16);
    chk("status write no latch", 8'h00, sr1);
    cmd({OP_SET_LATCH, 32'h0}, 8);
    cmd({OP_STAT_WR, 8'hFC, 24'h0}, 16);
    chk("status write", 8'hFC, sr1);
    step();
    wp_n = 1'b0;
    cmd({OP_SET_LATCH, 32'h0}, 8);
    cmd({OP_STAT_WR, 8'h00, 24'h0}, 16);
    chk("status write protected", 8'hFE, sr1);
    wr(24'h000000, 8'h00);
    chk("generic write protected", 8'hFE, sr1);
    step();
    wp_n = 1'b1;
    cmd({OP_STAT_WR, 8'h04, 24'h0}, 16);
    chk("status write unprotected", 8'h04, sr1);
  endtask

  // Every latency code, read back over a lane width that cycles single, dual, quad
  task automatic t_latency();
    for (int i = 0; i < 4; i++) begin
      step();
      proto = proto_t'(i % 3);
      wr(24'h000006, 8'(i));
      lat = int'(LAT_BASE) + i;
      rd("config five", {OP_CR5_RD, 32'h0}, 8, 8'(i));
    end
  endtask

  // Dedicated and generic reads, then a device reset reloads stored copies
  task automatic t_regs();
    wr(24'h000002, 8'hA5);
    rd("config one", {OP_CR1_RD, 32'h0}, 8, 8'hA5);
    wr(24'h070003, 8'h3C);
    rd("config two", {OP_CR2_RD, 32'h0}, 8, 8'h3C);
    wr(24'h000005, 8'h5A);
    rd("config four", {OP_CR4_RD, 32'h0}, 8, 8'h5A);
    rd("status two", {OP_SR2_RD, 32'h0}, 8, 8'h96);
    rd("generic read", {OP_GEN_RD, 24'h070003, 8'h0}, 32, 8'h3C);
    // Volatile-only status write must be undone by the reset below
    wr(24'h070000, 8'h08);
    chk("status one volatile only", 8'h08, sr1);
    // Status two is read only, so the write is refused and the latch survives
    wr(24'h000001, 8'h11);
    chk("latch after refused write", 8'h01, {7'h0, write_enable_latch});
    cmd({OP_SET_LATCH, 32'h0}, 8);
    step();
    dev_reset = 1'b1;
    step();
    dev_reset = 1'b0;
    repeat (3) step();
    chk("latch after reset", 8'h00, {7'h0, write_enable_latch});
    chk("status one after reset", 8'h04, sr1);
    rd("config two after reset", {OP_CR2_RD, 32'h0}, 8, 8'h00);
    rd("config one after reset", {OP_CR1_RD, 32'h0}, 8, 8'hA5);
  endtask

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    dev_reset = 1'b0;
    wp_n = 1'b1;
    write_in_progress = 1'b0;
    sr2 = 8'h96;
    proto = PROTO_SINGLE;
    errors = 0;
    n_tests = 0;
    lat = int'(LAT_BASE);
    repeat (3) step();
    rst = 1'b0;
    repeat (4) step();
    t_latch();
    t_status();
    t_latency();
    t_regs();
    give_verdict();
  end

  // Watchdog, about four times the expected run
  initial begin
    #250000;
    errors++;
    give_verdict();
  end
endmodule // write_latch_and_register_access_tb
`default_nettype wire
